// file: lls_pkg.sv
package lls_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL          = 8'h00;
  localparam logic [7:0]  ADDR_STATUS        = 8'h04;
  localparam int          CTRL_BURST_EN_BIT  = 0;
  localparam int          CTRL_PHASE_EN_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET         = 2'h3;
  localparam int          STAT_MODE_LSB      = 0;
  localparam int          STAT_SINGLE_BIT    = 3;
  localparam int          STAT_BROWNOUT_BIT  = 4;
  localparam int          STAT_HOLD_BIT      = 5;
  localparam int          STAT_STANDBY_BIT   = 6;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // ----------------------------------------------------------------
  // Sequencing and timing
  // ----------------------------------------------------------------
  localparam logic [2:0]  SOFT_LAST_STEP     = 3'h7;
  localparam logic [3:0]  ON_TIME_FULL       = 4'h8;
  localparam logic [3:0]  ON_TIME_NONE       = 4'h0;
  localparam logic [3:0]  PHASE_SHED_LAST    = 4'hd;
  localparam int          CLK_PERIOD_PS      = 4000;
  localparam int          BO_FILTER_TIME_US  = 100;
  localparam int          BO_HOLD_TIME_US    = 1000;
  localparam int          BO_FILTER_CYCLES   =
    (BO_FILTER_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          BO_HOLD_CYCLES     =
    (BO_HOLD_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LLS_FAULT, LLS_SOFTSTART, LLS_RUN, LLS_SOFT_OFF, LLS_BURST_STOP, LLS_SOFT_ON
  } lls_mode_e;

  typedef struct packed {
    logic comp_below_burst;
    logic comp_above_burst_hys;
    logic comp_below_phase_shed;
    logic comp_above_phase_shed_hys;
    logic phase_shed_below_burst;
    logic line_peak_high;
    logic output_sense_grounded;
    logic output_sense_deviates;
    logic output_sense_above_low;
    logic output_sense_above_95;
    logic line_below_brownout;
    logic comp_discharged;
    logic redundant_overvoltage_fault;
    logic supply_undervoltage_lockout;
    logic protection_fault;
    logic switch_cycle;
    logic line_half_cycle;
  } lls_sense_s;

  typedef struct packed {
    logic       gate_a_en;
    logic       gate_b_en;
    logic [3:0] on_time_eighths;
    logic       on_time_double;
    logic       comp_discharge;
    logic       softstart_high_current;
    logic       ea_high_gain;
    logic       burst_range_source_en;
    logic       brownout_hysteresis_sink;
    logic       standby;
  } lls_drive_s;

endpackage

// file: lls_sync.sv
`timescale 1ns/1ps
module lls_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // Two-flop synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

// file: lls_light_load_ctrl.sv
`timescale 1ns/1ps
module lls_light_load_ctrl
  import lls_pkg::*;
#(
  parameter int BO_FILTER = lls_pkg::BO_FILTER_CYCLES,
  parameter int BO_HOLD   = lls_pkg::BO_HOLD_CYCLES,
  parameter int CNT_W     = 24
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire lls_pkg::lls_sense_s sense_pins,
  output lls_pkg::lls_drive_s     drive,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  import lls_pkg::*;

  localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(BO_FILTER - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(BO_HOLD - 1);

  // ----------------------------------------------------------------
  // Input synchronisation and cycle ticks
  // ----------------------------------------------------------------
  lls_sense_s s;
  logic       sw_prev;
  logic       half_prev;
  logic       sw_tick;
  logic       half_tick;

  lls_sync #(.WIDTH($bits(lls_sense_s))) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (sense_pins),
    .dout    (s)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_prev   <= 1'b0;
      half_prev <= 1'b0;
    end
    else
    begin
      sw_prev   <= s.switch_cycle;
      half_prev <= s.line_half_cycle;
    end
  end

  assign sw_tick   = s.switch_cycle & ~sw_prev;
  assign half_tick = s.line_half_cycle & ~half_prev;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    if (addr[7:2] == ADDR_CTRL[7:2])
      return 2'h1;
    else if (addr[7:2] == ADDR_STATUS[7:2])
      return 2'h2;
    else
      return 2'h0;
  endfunction

  logic [1:0]  ctrl;
  logic [1:0]  next_ctrl;
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic        w_strb0, next_w_strb0;
  logic        next_awready, next_wready, next_arready;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, status;

  lls_mode_e        mode, next_mode;
  logic             single, next_single;
  logic             bo, next_bo;
  logic [CNT_W-1:0] hold_cnt, next_hold_cnt;
  logic             hold_active;

  always_comb
  begin
    status = 32'h0;
    status[STAT_MODE_LSB +: 3] = mode;
    status[STAT_SINGLE_BIT]    = single;
    status[STAT_BROWNOUT_BIT]  = bo;
    status[STAT_HOLD_BIT]      = hold_active;
    status[STAT_STANDBY_BIT]   = s.output_sense_grounded;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ctrl    = ctrl;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb0 = w_strb0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata;
      next_w_strb0 = s_axi_wstrb[0];
    end
    if (next_aw_held && next_w_held && !next_bvalid)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case (reg_sel(next_aw_addr))
        2'h1:
        begin
          if (next_w_strb0)
            next_ctrl = next_w_data[1:0];
        end
        2'h2: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        2'h1: next_rdata = {30'h0, ctrl};
        2'h2: next_rdata = status;
        default:
        begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl          <= CTRL_RESET;
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      w_held        <= 1'b0;
      w_data        <= 32'h0;
      w_strb0       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      ctrl          <= next_ctrl;
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_strb0       <= next_w_strb0;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Brownout detection
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] filt_cnt, next_filt_cnt;

  assign hold_active = bo && (hold_cnt != HOLD_LAST);

  always_comb
  begin
    next_bo       = bo;
    next_filt_cnt = filt_cnt;
    next_hold_cnt = hold_cnt;
    if (mode == LLS_BURST_STOP)
      next_filt_cnt = '0;
    else if (!bo)
    begin
      if (!s.line_below_brownout)
        next_filt_cnt = '0;
      else if (filt_cnt == FILT_LAST)
      begin
        next_bo       = 1'b1;
        next_filt_cnt = '0;
        next_hold_cnt = '0;
      end
      else
        next_filt_cnt = filt_cnt + 1'b1;
    end
    else if (hold_active)
      next_hold_cnt = hold_cnt + 1'b1;
    else if (!s.line_below_brownout)
      next_bo = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bo       <= 1'b0;
      filt_cnt <= '0;
      hold_cnt <= '0;
    end
    else
    begin
      bo       <= next_bo;
      filt_cnt <= next_filt_cnt;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  logic [2:0] step, next_step;
  logic       fault_any;

  assign fault_any = s.redundant_overvoltage_fault | bo | s.output_sense_grounded
                   | s.supply_undervoltage_lockout | s.protection_fault;

  always_comb
  begin
    next_mode = mode;
    next_step = step;
    case (mode)
      LLS_FAULT:
      begin
        if (!fault_any && s.comp_discharged)
          next_mode = LLS_SOFTSTART;
      end
      LLS_SOFTSTART:
      begin
        if (s.output_sense_above_95)
          next_mode = LLS_RUN;
      end
      LLS_RUN:
      begin
        if (ctrl[CTRL_BURST_EN_BIT] && s.comp_below_burst)
        begin
          next_mode = LLS_SOFT_OFF;
          next_step = 3'h0;
        end
      end
      LLS_SOFT_OFF:
      begin
        if (sw_tick)
        begin
          if (step == SOFT_LAST_STEP)
            next_mode = LLS_BURST_STOP;
          else
            next_step = step + 1'b1;
        end
      end
      LLS_BURST_STOP:
      begin
        if (s.comp_above_burst_hys)
        begin
          next_mode = LLS_SOFT_ON;
          next_step = 3'h0;
        end
      end
      LLS_SOFT_ON:
      begin
        if (sw_tick)
        begin
          if (step == SOFT_LAST_STEP)
            next_mode = LLS_RUN;
          else
            next_step = step + 1'b1;
        end
      end
      default: next_mode = LLS_FAULT;
    endcase
    if (fault_any)
      next_mode = LLS_FAULT;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode <= LLS_FAULT;
      step <= 3'h0;
    end
    else
    begin
      mode <= next_mode;
      step <= next_step;
    end
  end

  // ----------------------------------------------------------------
  // Phase management
  // ----------------------------------------------------------------
  logic [3:0] ps_cnt, next_ps_cnt;
  logic       soft_ramp;

  assign soft_ramp = (mode == LLS_SOFT_ON) || (mode == LLS_SOFT_OFF);

  always_comb
  begin
    next_single = single;
    next_ps_cnt = ps_cnt;
    if (mode == LLS_SOFTSTART || mode == LLS_FAULT)
    begin
      next_single = 1'b0;
      next_ps_cnt = 4'h0;
    end
    else if (soft_ramp && s.phase_shed_below_burst)
      next_single = 1'b1;
    else if (s.comp_below_burst)
      next_single = 1'b1;
    else if (s.comp_above_phase_shed_hys)
    begin
      next_single = 1'b0;
      next_ps_cnt = 4'h0;
    end
    else if (!s.comp_below_phase_shed || !ctrl[CTRL_PHASE_EN_BIT])
      next_ps_cnt = 4'h0;
    else if (!single && half_tick)
    begin
      if (ps_cnt == PHASE_SHED_LAST)
      begin
        next_single = 1'b1;
        next_ps_cnt = 4'h0;
      end
      else
        next_ps_cnt = ps_cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      single <= 1'b0;
      ps_cnt <= 4'h0;
    end
    else
    begin
      single <= next_single;
      ps_cnt <= next_ps_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  lls_drive_s next_drive;
  logic       next_switching;

  always_comb
  begin
    next_switching = (next_mode == LLS_SOFTSTART) || (next_mode == LLS_RUN)
                   || (next_mode == LLS_SOFT_OFF) || (next_mode == LLS_SOFT_ON);
    next_drive = '0;
    next_drive.gate_a_en      = next_switching;
    next_drive.gate_b_en      = next_switching && !next_single;
    next_drive.on_time_double = next_switching && next_single;
    case (next_mode)
      LLS_SOFT_OFF: next_drive.on_time_eighths = ON_TIME_FULL - {1'b0, next_step};
      LLS_SOFT_ON:  next_drive.on_time_eighths = {1'b0, next_step} + 4'h1;
      LLS_RUN, LLS_SOFTSTART: next_drive.on_time_eighths = ON_TIME_FULL;
      default: next_drive.on_time_eighths = ON_TIME_NONE;
    endcase
    next_drive.comp_discharge         = next_mode == LLS_FAULT;
    next_drive.softstart_high_current = (next_mode == LLS_SOFTSTART)
                                      && !s.output_sense_above_low;
    next_drive.ea_high_gain           = s.output_sense_deviates;
    next_drive.burst_range_source_en  = s.line_peak_high;
    next_drive.brownout_hysteresis_sink = next_bo;
    next_drive.standby                = s.output_sense_grounded;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      drive <= '0;
    else
      drive <= next_drive;
  end

endmodule

// file: lls_ctrl_props.sv
`timescale 1ns/1ps
module lls_ctrl_props
  import lls_pkg::*;
#(
  parameter int BO_FILTER = 8,
  parameter int BO_HOLD   = 16,
  parameter int CNT_W     = 24
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire lls_pkg::lls_sense_s sense_pins,
  input wire lls_pkg::lls_drive_s drive
);
  // ----------------
  // Helpers
  // ----------------
  logic [7:0] below_cnt;
  logic [7:0] next_below_cnt;

  // Consecutive clocks with the line below the brownout level
  always_comb
  begin
    next_below_cnt = below_cnt + 8'h01;
    if (!sense_pins.line_below_brownout)
      next_below_cnt = 8'h00;
    else if (below_cnt == 8'hff)
      next_below_cnt = below_cnt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      below_cnt <= 8'h00;
    else
      below_cnt <= next_below_cnt;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ramp_active;
    drive.gate_a_en && drive.on_time_eighths != ON_TIME_FULL
      && drive.on_time_eighths != ON_TIME_NONE;
  endsequence

  sequence held_fault;
    sense_pins.protection_fault[*3];
  endsequence

  // ----------------
  // Assertions
  // ----------------
  a_gain_follow:
    assert property (drive.ea_high_gain == $past(sense_pins.output_sense_deviates, 3))
    else $error("gain select wrong");
  a_range_source:
    assert property (drive.burst_range_source_en == $past(sense_pins.line_peak_high, 3))
    else $error("range source wrong");
  a_standby_disable:
    assert property (sense_pins.output_sense_grounded[*3] |=> drive.standby && drive.comp_discharge)
    else $error("standby missing");
  a_fault_discharge:
    assert property (held_fault |=> drive.comp_discharge && !drive.gate_a_en && !drive.gate_b_en)
    else $error("fault not acted on");
  a_softstart_dual:
    assert property (drive.softstart_high_current
      |-> drive.gate_a_en && drive.gate_b_en && !drive.on_time_double)
    else $error("soft-start not dual");
  a_brownout_filter:
    assert property ($rose(drive.brownout_hysteresis_sink) |-> $past(below_cnt, 3) >= BO_FILTER - 1)
    else $error("brownout too early");
  a_hold_blocks:
    assert property ($rose(drive.brownout_hysteresis_sink) |=> (drive.brownout_hysteresis_sink
      && !drive.gate_a_en && !drive.gate_b_en && drive.comp_discharge)[*8])
    else $error("hold not kept");
  a_ramp_single:
    assert property (sense_pins.phase_shed_below_burst[*4] ##0 ramp_active |-> !drive.gate_b_en)
    else $error("ramp not single");
  a_ramp_step:
    assert property (drive.on_time_eighths != ON_TIME_NONE && $past(drive.on_time_eighths) != 4'h0
      |-> drive.on_time_eighths <= ON_TIME_FULL
        && (drive.on_time_eighths == $past(drive.on_time_eighths)
        || drive.on_time_eighths == $past(drive.on_time_eighths) + 4'h1
        || drive.on_time_eighths + 4'h1 == $past(drive.on_time_eighths)))
    else $error("on-time step wrong");
endmodule

// file: lls_power_stage.sv
`timescale 1ns/1ps
module lls_power_stage
  import lls_pkg::*;
(
  input  wire logic                aclk,
  input  wire lls_pkg::lls_sense_s cmd,
  input  wire lls_pkg::lls_drive_s drive,
  output lls_pkg::lls_sense_s      sense_pins
);
  logic [2:0] sw_div   = 3'h0;
  logic [4:0] line_div = 5'h00;
  logic [3:0] comp_lvl = 4'h0;

  // ----------------
  // Stage and node
  // ----------------
  // Switching ticks stand still while the gates are off
  always_ff @(posedge aclk)
  begin
    sw_div <= drive.gate_a_en ? sw_div + 3'h1 : 3'h0;
    line_div <= line_div + 5'h01;
    if (drive.comp_discharge && comp_lvl != 4'h0)
      comp_lvl <= comp_lvl - 4'h1;
    else if (!drive.comp_discharge && comp_lvl != 4'hf)
      comp_lvl <= comp_lvl + 4'h1;
  end

  always_comb
  begin
    sense_pins = cmd;
    sense_pins.switch_cycle = sw_div[2];
    sense_pins.line_half_cycle = line_div[4];
    sense_pins.comp_discharged = (comp_lvl == 4'h0);
  end
endmodule

// file: lls_light_load_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("unexpected %s exp %0h got %0h", nm, e, g); \
    end \
  end
module lls_light_load_ctrl_tb;
  import lls_pkg::*;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  lls_sense_s  cmd     = '0;
  lls_sense_s  sense_pins;
  lls_drive_s  drive;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [3:0]  wstrb   = 4'hf;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  int          err_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;

  always #2 aclk = ~aclk;

  lls_power_stage lls_power_stage_i (.aclk(aclk), .cmd(cmd), .drive(drive),
    .sense_pins(sense_pins));
  lls_light_load_ctrl #(.BO_FILTER(8), .BO_HOLD(16)) lls_light_load_ctrl_i (
    .aclk(aclk), .aresetn(aresetn), .sense_pins(sense_pins), .drive(drive),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ----------------
  // Tasks
  // ----------------
  task automatic finish_test;
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    `CHK("rresp", er, rresp)
  endtask

  task automatic wait_mode(input logic [2:0] m);
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'hffff_ffff;
    while (s[2:0] !== m && n < 200)
    begin
      rd(ADDR_STATUS, RESP_OKAY, s);
      n++;
    end
    `CHK("mode", m, s[2:0])
  endtask

  // Follows each on-time change; stp of 4'hf steps down
  task automatic ramp(input logic [3:0] e, input logic [3:0] stp);
    logic [3:0] prev;
    int n;
    prev = drive.on_time_eighths;
    repeat (8)
    begin
      n = 0;
      while (drive.on_time_eighths === prev && n < 100)
      begin
        @(posedge aclk);
        n++;
      end
      `CHK("on_time", e, drive.on_time_eighths)
      prev = drive.on_time_eighths;
      e = e + stp;
    end
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_count++;
      finish_test();
    end
  end

  // ----------------
  // Scenarios
  // ----------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, RESP_OKAY, d);
    `CHK("ctrl", CTRL_RESET, d[1:0])
    rd(8'h08, RESP_SLVERR, d);
    `CHK("rdata", 32'h0, d)
    wr(8'h0c, 32'h0, RESP_SLVERR);
    wstrb <= 4'h0;
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    wstrb <= 4'hf;
    wr(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY, d);
    `CHK("ctrl", CTRL_RESET, d[1:0])
    wait_mode(3'h1);
    `CHK("ss_high", 1'b1, drive.softstart_high_current)
    cmd.comp_below_burst <= 1'b1;
    repeat (40) @(posedge aclk);
    wait_mode(3'h1);
    `CHK("gate_b", 1'b1, drive.gate_b_en)
    cmd.comp_below_burst <= 1'b0;
    cmd.output_sense_above_low <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK("ss_high", 1'b0, drive.softstart_high_current)
    cmd.output_sense_above_95 <= 1'b1;
    wait_mode(3'h2);
    cmd.phase_shed_below_burst <= 1'b1;
    cmd.comp_below_burst <= 1'b1;
    ramp(4'h7, 4'hf);
    wait_mode(3'h4);
    `CHK("gate_a", 1'b0, drive.gate_a_en)
    cmd.line_below_brownout <= 1'b1;
    repeat (30) @(posedge aclk);
    `CHK("sink", 1'b0, drive.brownout_hysteresis_sink)
    cmd.line_below_brownout <= 1'b0;
    cmd.comp_below_burst <= 1'b0;
    cmd.comp_above_burst_hys <= 1'b1;
    ramp(4'h1, 4'h1);
    wait_mode(3'h2);
    cmd.comp_above_burst_hys <= 1'b0;
    cmd.phase_shed_below_burst <= 1'b0;
    cmd.comp_above_phase_shed_hys <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("gate_b", 1'b1, drive.gate_b_en)
    cmd.comp_above_phase_shed_hys <= 1'b0;
    cmd.comp_below_phase_shed <= 1'b1;
    repeat (320) @(posedge aclk);
    rd(ADDR_STATUS, RESP_OKAY, d);
    `CHK("single", 1'b0, d[STAT_SINGLE_BIT])
    repeat (320) @(posedge aclk);
    `CHK("double", 2'h2, {drive.on_time_double, drive.gate_b_en})
    cmd.comp_below_phase_shed <= 1'b0;
    cmd.comp_above_phase_shed_hys <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("gate_b", 1'b1, drive.gate_b_en)
    cmd.comp_above_phase_shed_hys <= 1'b0;
    wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY, d);
    `CHK("ctrl", 2'h2, d[1:0])
    cmd.comp_below_burst <= 1'b1;
    cmd.line_peak_high <= 1'b1;
    cmd.output_sense_deviates <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("forced", 1'b1, drive.on_time_double)
    `CHK("range", 1'b1, drive.burst_range_source_en)
    `CHK("gain", 1'b1, drive.ea_high_gain)
    cmd.comp_below_burst <= 1'b0;
    cmd.line_peak_high <= 1'b0;
    cmd.output_sense_deviates <= 1'b0;
    wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    cmd.line_below_brownout <= 1'b1;
    for (int i = 0; i < 40 && drive.brownout_hysteresis_sink !== 1'b1; i++)
      @(posedge aclk);
    rd(ADDR_STATUS, RESP_OKAY, d);
    `CHK("bo_hold", 2'h3, d[5:4])
    `CHK("gates", 2'h0, {drive.gate_a_en, drive.gate_b_en})
    repeat (40) @(posedge aclk);
    rd(ADDR_STATUS, RESP_OKAY, d);
    `CHK("bo_held", 2'h1, d[5:4])
    `CHK("sink", 2'h3, {drive.brownout_hysteresis_sink, drive.comp_discharge})
    cmd.output_sense_above_95 <= 1'b0;
    cmd.line_below_brownout <= 1'b0;
    wait_mode(3'h1);
    cmd.output_sense_above_95 <= 1'b1;
    wait_mode(3'h2);
    cmd.protection_fault <= 1'b1;
    repeat (3) @(posedge aclk);
    cmd.protection_fault <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK("latched", 2'h1, {drive.gate_a_en, drive.comp_discharge})
    wait_mode(3'h2);
    cmd.output_sense_above_95 <= 1'b0;
    cmd.output_sense_grounded <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK("standby", 2'h3, {drive.standby, drive.comp_discharge})
    cmd.output_sense_grounded <= 1'b0;
    wait_mode(3'h1);
    finish_test();
  end
endmodule

bind lls_light_load_ctrl lls_ctrl_props #(
  .BO_FILTER(BO_FILTER),
  .BO_HOLD(BO_HOLD),
  .CNT_W(CNT_W)
) lls_ctrl_props_i (
  .aclk(aclk),
  .aresetn(aresetn),
  .sense_pins(sense_pins),
  .drive(drive)
);
